// >>> hrs_regs.svh
`ifndef HRS_REGS_SVH
`define HRS_REGS_SVH
`define HRS_CLK_PERIOD_NS 4
`define HRS_MS_NS 1000000
`define HRS_DWELL_MAX_MS 13'h1388
`define HRS_ERR_NO_DRIVER 11'h0C2
`define HRS_ERR_LIM_FWD 11'h3E9
`define HRS_ERR_LIM_REV 11'h3EA
`define HRS_ERR_SHIFT_FWD 11'h44E
`define HRS_ERR_SHIFT_REV 11'h44F
`define HRS_SYNC_W 5
`define HRS_PIN_FLS 0
`define HRS_PIN_RLS 1
`define HRS_PIN_DOG 2
`define HRS_PIN_ZERO 3
`define HRS_PIN_DRV_DONE 4
`endif

// >>> hrs_pkg.sv
package hrs_pkg;
  typedef enum logic [3:0] {
    HRS_M_PROX_DOG, HRS_M_COUNT, HRS_M_DATA_SET, HRS_M_DOG_CRADLE, HRS_M_STOPPER,
    HRS_M_LIMIT_COMB, HRS_M_SCALE, HRS_M_DOGLESS_A, HRS_M_DOGLESS_B, HRS_M_DOGLESS_C,
    HRS_M_DRIVER
  } hrs_method_t;
  typedef enum logic [3:0] {
    HRS_IDLE, HRS_DRV, HRS_SEARCH, HRS_DECEL_LIM, HRS_DWELL_LIM, HRS_REVERSE,
    HRS_DECEL_DOG, HRS_DWELL_DOG, HRS_SHIFT
  } hrs_state_t;
  typedef struct packed {
    logic move;
    logic dir_fwd;
    logic creep;
    logic stop;
  } hrs_motion_t;
  typedef struct packed {
    logic valid;
    logic major;
    logic [10:0] code;
  } hrs_err_t;
endpackage : hrs_pkg

// >>> hrs_sequencer.sv
// Behaviour
// - driver homing method hands the whole homing motion to the stepping driver
// - driver homing without a stepping driver raises minor error 194, no homing
// - a stop cause during driver homing halts it; driver decides how to stop
// - per-axis retry enable, 0 off and 1 on, default off
// - per-axis retry dwell 0 to 5000 ms, default 0, used at each stop
// - retry, start outside limits, home lies in homing direction: ordinary homing
// - home lies opposite: stop when dog turns off, then home in homing direction
// - same dwell after limit reversal stop and after dog-off stop
// - retry only for dog, count, cradle and dogless A methods
// - retry limit hit decelerates, reverses, raises no limit major error
// - home is zero-signal position plus configured shift amount
// - shift amount is signed 32-bit in axis units, default 0
// - shift speed select, 0 homing speed, 1 creep speed, default 0
// - shift past a limit raises major 1102 or 1103, homing left incomplete
// - monitor values and status update only after shift travel ends
`timescale 1ns/1ps
`include "hrs_regs.svh"
module hrs_sequencer #(
  parameter int unsigned CYC_PER_MS = `HRS_MS_NS / `HRS_CLK_PERIOD_NS
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  input wire hrs_pkg::hrs_method_t method,
  input wire logic home_dir_fwd,
  input wire logic retry_en,
  input wire logic [12:0] retry_dwell_ms,
  input wire logic signed [31:0] shift_amount,
  input wire logic shift_creep,
  input wire logic driver_present,
  input wire logic stop_cause,
  input wire logic motion_stopped,
  input wire logic home_is_fwd,
  input wire logic signed [31:0] cur_pos,
  input wire logic fwd_limit_switch,
  input wire logic rev_limit_switch,
  input wire logic prox_dog,
  input wire logic zero_signal,
  input wire logic drv_home_done,
  output hrs_pkg::hrs_motion_t motion,
  output logic drv_home_req,
  output logic drv_home_abort,
  output hrs_pkg::hrs_err_t err,
  output logic busy,
  output logic home_done,
  output logic monitor_update,
  output logic signed [31:0] home_pos
);
  // pins are asynchronous to clock; stage one feeds stage two only
  logic [`HRS_SYNC_W-1:0] sync1_q;
  logic [`HRS_SYNC_W-1:0] sync2_q;
  logic dog_prev_q;
  hrs_pkg::hrs_state_t state_q, state_d;
  hrs_pkg::hrs_motion_t motion_q, motion_d;
  hrs_pkg::hrs_err_t err_q, err_d;
  logic drv_req_q, drv_req_d;
  logic drv_abort_q, drv_abort_d;
  logic done_q, done_d;
  logic mon_q, mon_d;
  logic busy_q;
  logic signed [31:0] home_pos_q, home_pos_d;
  logic signed [32:0] target_q, target_d;
  logic retry_q, retry_d;
  logic creep_q, creep_d;
  logic [12:0] dwell_q, dwell_d;
  logic [31:0] ms_cnt_q, ms_cnt_d;

  function automatic logic retry_usable(input hrs_pkg::hrs_method_t m);
    retry_usable = (m == hrs_pkg::HRS_M_PROX_DOG) || (m == hrs_pkg::HRS_M_COUNT) ||
                   (m == hrs_pkg::HRS_M_DOG_CRADLE) || (m == hrs_pkg::HRS_M_DOGLESS_A);
  endfunction : retry_usable

  function automatic hrs_pkg::hrs_motion_t mv(input logic fwd, input logic creep);
    mv = '{move: 1'b1, dir_fwd: fwd, creep: creep, stop: 1'b0};
  endfunction : mv
  function automatic hrs_pkg::hrs_err_t er(input logic major, input logic [10:0] code);
    er = '{valid: 1'b1, major: major, code: code};
  endfunction : er

  wire logic fls_s = sync2_q[`HRS_PIN_FLS];
  wire logic rls_s = sync2_q[`HRS_PIN_RLS];
  wire logic dog_s = sync2_q[`HRS_PIN_DOG];
  wire logic zero_s = sync2_q[`HRS_PIN_ZERO];
  wire logic drv_done_s = sync2_q[`HRS_PIN_DRV_DONE];
  wire logic dog_fall = dog_prev_q && !dog_s;
  // only the switch ahead of the travel direction counts
  wire logic lim_ahead = motion_q.dir_fwd ? fls_s : rls_s;
  wire logic [10:0] lim_code = motion_q.dir_fwd ? `HRS_ERR_LIM_FWD : `HRS_ERR_LIM_REV;
  wire logic [10:0] shift_code = motion_q.dir_fwd ? `HRS_ERR_SHIFT_FWD : `HRS_ERR_SHIFT_REV;
  wire logic [12:0] dwell_load = (retry_dwell_ms > `HRS_DWELL_MAX_MS) ?
                                 `HRS_DWELL_MAX_MS : retry_dwell_ms;
  wire logic ms_tick = (ms_cnt_q == CYC_PER_MS - 1);
  wire logic dwell_over = (dwell_q == 13'h0000);
  wire logic signed [32:0] pos_ext = {cur_pos[31], cur_pos};
  wire logic signed [32:0] zero_target = pos_ext + {shift_amount[31], shift_amount};
  wire logic shift_reached = motion_q.dir_fwd ? (pos_ext >= target_q) : (pos_ext <= target_q);
  wire logic in_dwell = (state_q == hrs_pkg::HRS_DWELL_LIM) || (state_q == hrs_pkg::HRS_DWELL_DOG);
  wire logic busy_d = (state_d != hrs_pkg::HRS_IDLE); // busy falls with the done pulse

  always_comb begin
    state_d = state_q;
    motion_d = motion_q;
    err_d = err_q;
    drv_req_d = 1'b0;
    drv_abort_d = 1'b0;
    done_d = 1'b0;
    mon_d = 1'b0;
    home_pos_d = home_pos_q;
    target_d = target_q;
    retry_d = retry_q;
    creep_d = creep_q;
    dwell_d = dwell_q;
    ms_cnt_d = (in_dwell && !ms_tick) ? ms_cnt_q + 32'h1 : 32'h0;
    unique case (state_q)
      hrs_pkg::HRS_IDLE: begin
        motion_d = '0;
        if (start) begin
          err_d = '0;
          retry_d = retry_en && retry_usable(method);
          creep_d = shift_creep;
          if (method == hrs_pkg::HRS_M_DRIVER) begin
            if (!driver_present) begin
              err_d = er(1'b0, `HRS_ERR_NO_DRIVER);
            end else begin
              drv_req_d = 1'b1;
              state_d = hrs_pkg::HRS_DRV;
            end
          end else if (retry_en && retry_usable(method) && (home_is_fwd != home_dir_fwd)) begin
            motion_d = mv(!home_dir_fwd, 1'b0);
            state_d = hrs_pkg::HRS_REVERSE;
          end else begin
            motion_d = mv(home_dir_fwd, 1'b0);
            state_d = hrs_pkg::HRS_SEARCH;
          end
        end
      end
      hrs_pkg::HRS_DRV: begin
        // direction and stop profile belong to the driver's own parameters
        if (stop_cause) begin
          drv_abort_d = 1'b1;
          state_d = hrs_pkg::HRS_IDLE;
        end else if (drv_done_s) begin
          done_d = 1'b1;
          mon_d = 1'b1;
          home_pos_d = cur_pos;
          state_d = hrs_pkg::HRS_IDLE;
        end else begin
          drv_req_d = 1'b1;
        end
      end
      hrs_pkg::HRS_SEARCH: begin
        if (stop_cause) begin
          motion_d = '{move: 1'b0, dir_fwd: motion_q.dir_fwd, creep: 1'b0, stop: 1'b1};
          state_d = hrs_pkg::HRS_IDLE;
        end else if (lim_ahead) begin
          motion_d.stop = 1'b1;
          motion_d.move = 1'b0;
          if (retry_q) begin
            dwell_d = dwell_load;
            state_d = hrs_pkg::HRS_DECEL_LIM;
          end else begin
            err_d = er(1'b1, lim_code);
            state_d = hrs_pkg::HRS_IDLE;
          end
        end else if (zero_s) begin
          target_d = zero_target;
          motion_d = mv(shift_amount >= 0, creep_q);
          state_d = hrs_pkg::HRS_SHIFT;
        end
      end
      hrs_pkg::HRS_DECEL_LIM: begin
        if (motion_stopped) begin
          motion_d.stop = 1'b0;
          state_d = hrs_pkg::HRS_DWELL_LIM;
        end
      end
      hrs_pkg::HRS_DWELL_LIM: begin
        if (dwell_over) begin
          motion_d = mv(!home_dir_fwd, 1'b0);
          state_d = hrs_pkg::HRS_REVERSE;
        end else if (ms_tick) begin
          dwell_d = dwell_q - 13'h0001;
        end
      end
      hrs_pkg::HRS_REVERSE: begin
        if (stop_cause) begin
          motion_d = '{move: 1'b0, dir_fwd: motion_q.dir_fwd, creep: 1'b0, stop: 1'b1};
          state_d = hrs_pkg::HRS_IDLE;
        end else if (dog_fall) begin
          motion_d.stop = 1'b1;
          motion_d.move = 1'b0;
          dwell_d = dwell_load;
          state_d = hrs_pkg::HRS_DECEL_DOG;
        end else if (lim_ahead) begin
          motion_d = '{move: 1'b0, dir_fwd: motion_q.dir_fwd, creep: 1'b0, stop: 1'b1};
          err_d = er(1'b1, lim_code);
          state_d = hrs_pkg::HRS_IDLE;
        end
      end
      hrs_pkg::HRS_DECEL_DOG: begin
        if (motion_stopped) begin
          motion_d.stop = 1'b0;
          state_d = hrs_pkg::HRS_DWELL_DOG;
        end
      end
      hrs_pkg::HRS_DWELL_DOG: begin
        if (dwell_over) begin
          motion_d = mv(home_dir_fwd, 1'b0);
          state_d = hrs_pkg::HRS_SEARCH;
        end else if (ms_tick) begin
          dwell_d = dwell_q - 13'h0001;
        end
      end
      hrs_pkg::HRS_SHIFT: begin
        if (lim_ahead) begin
          motion_d = '{move: 1'b0, dir_fwd: motion_q.dir_fwd, creep: 1'b0, stop: 1'b1};
          err_d = er(1'b1, shift_code);
          state_d = hrs_pkg::HRS_IDLE;
        end else if (stop_cause) begin
          motion_d = '{move: 1'b0, dir_fwd: motion_q.dir_fwd, creep: 1'b0, stop: 1'b1};
          state_d = hrs_pkg::HRS_IDLE;
        end else if (shift_reached) begin
          motion_d = '0;
          done_d = 1'b1;
          mon_d = 1'b1;
          home_pos_d = cur_pos;
          state_d = hrs_pkg::HRS_IDLE;
        end
      end
      default: begin
        state_d = hrs_pkg::HRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
      dog_prev_q <= 1'b0;
    end else begin
      sync1_q <= {drv_home_done, zero_signal, prox_dog, rev_limit_switch, fwd_limit_switch};
      sync2_q <= sync1_q;
      dog_prev_q <= sync2_q[`HRS_PIN_DOG];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_q <= hrs_pkg::HRS_IDLE;
      motion_q <= '0;
      err_q <= '0;
      drv_req_q <= 1'b0;
      drv_abort_q <= 1'b0;
      done_q <= 1'b0;
      mon_q <= 1'b0;
      busy_q <= 1'b0;
      home_pos_q <= '0;
      target_q <= '0;
      retry_q <= 1'b0;
      creep_q <= 1'b0;
      dwell_q <= '0;
      ms_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      motion_q <= motion_d;
      err_q <= err_d;
      drv_req_q <= drv_req_d;
      drv_abort_q <= drv_abort_d;
      done_q <= done_d;
      mon_q <= mon_d;
      busy_q <= busy_d;
      home_pos_q <= home_pos_d;
      target_q <= target_d;
      retry_q <= retry_d;
      creep_q <= creep_d;
      dwell_q <= dwell_d;
      ms_cnt_q <= ms_cnt_d;
    end
  end

  assign motion = motion_q;
  assign drv_home_req = drv_req_q;
  assign drv_home_abort = drv_abort_q;
  assign err = err_q;
  assign busy = busy_q;
  assign home_done = done_q;
  assign monitor_update = mon_q;
  assign home_pos = home_pos_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence drv_start_s;
    (state_q == hrs_pkg::HRS_IDLE) && start && (method == hrs_pkg::HRS_M_DRIVER);
  endsequence
  sequence retry_lim_s;
    (state_q == hrs_pkg::HRS_SEARCH) && !stop_cause && lim_ahead && retry_q;
  endsequence

  no_driver_err_a: assert property (drv_start_s and !driver_present |=>
    err_q.valid && !err_q.major && (err_q.code == `HRS_ERR_NO_DRIVER) && !drv_req_q)
    else $error("missing driver did not give minor error");
  driver_handoff_a: assert property (drv_start_s and driver_present |=>
    drv_req_q && (state_q == hrs_pkg::HRS_DRV) && !motion_q.move)
    else $error("driver homing not handed over");
  driver_stop_a: assert property ((state_q == hrs_pkg::HRS_DRV) && stop_cause |=>
    drv_abort_q && !drv_req_q && !busy)
    else $error("stop cause did not halt driver homing");
  retry_gate_a: assert property ((state_q == hrs_pkg::HRS_IDLE) && start &&
    !retry_usable(method) |=> !retry_q)
    else $error("retry armed for unsupported method");
  retry_noerr_a: assert property (retry_lim_s |=> !err_q.valid && motion_q.stop &&
    (state_q == hrs_pkg::HRS_DECEL_LIM))
    else $error("retry limit raised error");
  reverse_start_a: assert property ((state_q == hrs_pkg::HRS_IDLE) && start &&
    (method != hrs_pkg::HRS_M_DRIVER) && retry_en && retry_usable(method) &&
    (home_is_fwd != home_dir_fwd) |=> motion_q.move && (motion_q.dir_fwd == !home_dir_fwd))
    else $error("retry did not start reversed");
  dwell_hold_a: assert property (in_dwell && !dwell_over |=> !motion_q.move)
    else $error("axis moved during dwell");
  dwell_step_a: assert property (in_dwell && ms_tick && !dwell_over |=>
    dwell_q == $past(dwell_q) - 13'h0001)
    else $error("dwell did not count down");
  shift_err_a: assert property ((state_q == hrs_pkg::HRS_SHIFT) && lim_ahead |=>
    err_q.valid && err_q.major && !home_done && ((err_q.code == `HRS_ERR_SHIFT_FWD) ||
    (err_q.code == `HRS_ERR_SHIFT_REV)))
    else $error("shift past limit not reported");
  shift_speed_a: assert property ((state_q == hrs_pkg::HRS_SEARCH) && !stop_cause &&
    !lim_ahead && zero_s |=> motion_q.move && (motion_q.creep == $past(creep_q)))
    else $error("shift speed not as selected");
  monitor_late_a: assert property (monitor_update |-> home_done &&
    ($past(state_q) == hrs_pkg::HRS_SHIFT || $past(state_q) == hrs_pkg::HRS_DRV))
    else $error("monitor updated before shift end");
endmodule : hrs_sequencer

// >>> hrs_axis_model.sv
`timescale 1ns/1ps
module hrs_axis_model #(
  parameter int STEP = 8,
  parameter int DECEL = 3,
  parameter int DRV_CYC = 20
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire hrs_pkg::hrs_motion_t motion,
  input wire logic drv_home_req,
  input wire logic drv_home_abort,
  input wire logic load,
  input wire logic signed [31:0] load_pos,
  output logic motion_stopped,
  output logic signed [31:0] cur_pos,
  output logic fwd_limit_switch,
  output logic rev_limit_switch,
  output logic prox_dog,
  output logic zero_signal,
  output logic drv_home_done
);
  int step_cnt;
  int dec_cnt;
  int drv_cnt;
  // slow steps keep every pin level well past the synchroniser latency
  assign fwd_limit_switch = cur_pos >= 32'sh3C;
  assign rev_limit_switch = cur_pos <= 32'sh0;
  assign prox_dog = cur_pos >= 32'sh28 && cur_pos <= 32'sh2D;
  assign zero_signal = cur_pos == 32'sh2F;
  assign motion_stopped = dec_cnt >= DECEL;
  assign drv_home_done = drv_cnt >= DRV_CYC;
  always @(posedge clock) begin
    if (!rst_b || load) begin
      cur_pos <= load_pos;
      step_cnt <= 0;
    end else if (motion.move && !motion.stop) begin
      step_cnt <= (step_cnt == STEP - 1) ? 0 : step_cnt + 1;
      if (step_cnt == STEP - 1) begin
        cur_pos <= motion.dir_fwd ? cur_pos + 32'sh1 : cur_pos - 32'sh1;
      end
    end
    dec_cnt <= (rst_b && motion.stop) ? dec_cnt + 1 : 0;
    // driver keeps its own direction; on abort it simply never reports done
    drv_cnt <= (rst_b && drv_home_req && !drv_home_abort) ? drv_cnt + 1 : 0;
  end
endmodule : hrs_axis_model

// >>> hrs_sequencer_tb.sv
`timescale 1ns/1ps
`include "hrs_regs.svh"
module hrs_sequencer_tb;
  logic clock, rst_b, start, home_dir_fwd, retry_en, shift_creep, driver_present;
  logic stop_cause, motion_stopped, home_is_fwd, load, drv_home_req, drv_home_abort;
  logic fwd_limit_switch, rev_limit_switch, prox_dog, zero_signal, drv_home_done;
  logic busy, home_done, monitor_update;
  logic [12:0] retry_dwell_ms;
  logic signed [31:0] shift_amount, cur_pos, home_pos, load_pos;
  hrs_pkg::hrs_method_t method;
  hrs_pkg::hrs_motion_t motion;
  hrs_pkg::hrs_err_t err;
  int err_total, comparisons, abort_at, still, max_still, dwells;
  logic done_seen, rev_seen, creep_seen, mon_bad, drv_seen, abort_seen;
  logic signed [31:0] sh_tab [3] = '{32'sh4, 32'sh0, -32'sh3};
  hrs_pkg::hrs_method_t ok_tab [4] = '{hrs_pkg::HRS_M_PROX_DOG, hrs_pkg::HRS_M_COUNT,
    hrs_pkg::HRS_M_DOG_CRADLE, hrs_pkg::HRS_M_DOGLESS_A};

  hrs_sequencer #(.CYC_PER_MS(4)) hrs_sequencer_i (.clock(clock), .rst_b(rst_b),
    .start(start), .method(method), .home_dir_fwd(home_dir_fwd), .retry_en(retry_en),
    .retry_dwell_ms(retry_dwell_ms), .shift_amount(shift_amount), .shift_creep(shift_creep),
    .driver_present(driver_present), .stop_cause(stop_cause),
    .motion_stopped(motion_stopped), .home_is_fwd(home_is_fwd), .cur_pos(cur_pos),
    .fwd_limit_switch(fwd_limit_switch), .rev_limit_switch(rev_limit_switch),
    .prox_dog(prox_dog), .zero_signal(zero_signal), .drv_home_done(drv_home_done),
    .motion(motion), .drv_home_req(drv_home_req), .drv_home_abort(drv_home_abort),
    .err(err), .busy(busy), .home_done(home_done), .monitor_update(monitor_update),
    .home_pos(home_pos));
  hrs_axis_model hrs_axis_model_i (.clock(clock), .rst_b(rst_b), .motion(motion),
    .drv_home_req(drv_home_req), .drv_home_abort(drv_home_abort), .load(load),
    .load_pos(load_pos), .motion_stopped(motion_stopped), .cur_pos(cur_pos),
    .fwd_limit_switch(fwd_limit_switch), .rev_limit_switch(rev_limit_switch),
    .prox_dog(prox_dog), .zero_signal(zero_signal), .drv_home_done(drv_home_done));

  always #2 clock = ~clock;

  task automatic complete_run();
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic home(input hrs_pkg::hrs_method_t m, input logic dfw, input logic rt,
    input logic hf, input logic cr, input logic signed [31:0] p0, input logic signed [31:0] sh);
    int n;
    @(negedge clock);
    method = m; home_dir_fwd = dfw; retry_en = rt; home_is_fwd = hf; shift_creep = cr;
    shift_amount = sh; load = 1'b1; load_pos = p0;
    @(negedge clock);
    load = 1'b0;
    // let the new pin levels pass the synchronisers before starting
    repeat (4) @(negedge clock);
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    {done_seen, rev_seen, creep_seen, mon_bad, drv_seen, abort_seen} = '0;
    n = 0; still = 0; max_still = 0; dwells = 0;
    while (busy === 1'b1 && n < 5000) begin
      @(negedge clock);
      n++;
      stop_cause = (abort_at != 0 && n == abort_at);
      if (motion.move === 1'b1 && motion.stop === 1'b0 && motion.dir_fwd === 1'b0) rev_seen = 1;
      if (motion.move === 1'b1 && motion.creep === 1'b1) creep_seen = 1;
      if (home_done !== monitor_update) mon_bad = 1;
      if (home_done === 1'b1) done_seen = 1;
      if (drv_home_req === 1'b1) drv_seen = 1;
      if (drv_home_abort === 1'b1) abort_seen = 1;
      // direction may stay set while parked, so only move and stop count
      still = (busy === 1'b1 && motion.move === 1'b0 && motion.stop === 1'b0) ? still + 1 : 0;
      if (still == 8) dwells++;
      if (still > max_still) max_still = still;
    end
    chk("home_timeout", 32'h0, {31'h0, n >= 5000});
  endtask : home

  task automatic finish_chk(input logic dn, input logic [12:0] e, input logic [31:0] p);
    chk("home_done", {31'h0, dn}, {31'h0, done_seen});
    chk("err", {19'h0, e}, {19'h0, err});
    chk("monitor_update", 32'h0, {31'h0, mon_bad});
    if (dn) chk("home_pos", p, home_pos);
  endtask : finish_chk

  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    complete_run();
  end

  initial begin
    clock = 1'b0; rst_b = 1'b0; start = 1'b0; method = hrs_pkg::HRS_M_PROX_DOG;
    home_dir_fwd = 1'b0; retry_en = 1'b0; retry_dwell_ms = 13'h2; shift_amount = 32'sh0;
    shift_creep = 1'b0; driver_present = 1'b0; stop_cause = 1'b0; home_is_fwd = 1'b0;
    load = 1'b0; load_pos = 32'sh32; abort_at = 0; err_total = 0; comparisons = 0;
    repeat (3) @(negedge clock);
    chk("reset", 32'h0, {13'h0, err, motion, busy, home_done});
    rst_b = 1'b1;
    for (int i = 0; i < 3; i++) begin
      home(hrs_pkg::HRS_M_PROX_DOG, 1'b0, 1'b1, 1'b0, i[0], 32'sh37, sh_tab[i]);
      finish_chk(1'b1, 13'h0, 32'sh2F + sh_tab[i]);
      chk("creep", {31'h0, i[0]}, {31'h0, creep_seen});
    end
    for (int i = 0; i < 4; i++) begin
      home(ok_tab[i], 1'b1, 1'b1, 1'b1, 1'b0, 32'sh32, 32'sh2);
      finish_chk(1'b1, 13'h0, 32'sh31);
      chk("reverse", 32'h1, {31'h0, rev_seen});
      chk("dwell", 32'h1, {31'h0, max_still >= 8});
      chk("dwell_count", 32'h2, dwells);
    end
    home(hrs_pkg::HRS_M_PROX_DOG, 1'b1, 1'b1, 1'b0, 1'b0, 32'sh2B, 32'sh0);
    finish_chk(1'b1, 13'h0, 32'sh2F);
    chk("dwell", 32'h1, {31'h0, max_still >= 8});
    chk("dwell_count", 32'h1, dwells);
    home(hrs_pkg::HRS_M_PROX_DOG, 1'b1, 1'b0, 1'b1, 1'b0, 32'sh32, 32'sh2);
    finish_chk(1'b0, {2'b11, `HRS_ERR_LIM_FWD}, 32'h0);
    home(hrs_pkg::HRS_M_DOGLESS_B, 1'b1, 1'b1, 1'b1, 1'b0, 32'sh32, 32'sh2);
    finish_chk(1'b0, {2'b11, `HRS_ERR_LIM_FWD}, 32'h0);
    home(hrs_pkg::HRS_M_SCALE, 1'b0, 1'b1, 1'b1, 1'b0, 32'sh1E, 32'sh0);
    finish_chk(1'b0, {2'b11, `HRS_ERR_LIM_REV}, 32'h0);
    home(hrs_pkg::HRS_M_PROX_DOG, 1'b1, 1'b0, 1'b1, 1'b0, 32'sh2C, 32'sh14);
    finish_chk(1'b0, {2'b11, `HRS_ERR_SHIFT_FWD}, 32'h0);
    home(hrs_pkg::HRS_M_PROX_DOG, 1'b0, 1'b0, 1'b0, 1'b0, 32'sh37, -32'sh32);
    finish_chk(1'b0, {2'b11, `HRS_ERR_SHIFT_REV}, 32'h0);
    home(hrs_pkg::HRS_M_DRIVER, 1'b1, 1'b0, 1'b1, 1'b0, 32'sh32, 32'sh0);
    finish_chk(1'b0, {2'b10, `HRS_ERR_NO_DRIVER}, 32'h0);
    chk("drv_home_req", 32'h0, {31'h0, drv_seen});
    driver_present = 1'b1;
    home(hrs_pkg::HRS_M_DRIVER, 1'b0, 1'b0, 1'b1, 1'b0, 32'sh32, 32'sh0);
    chk("drv_home_req", 32'h1, {31'h0, drv_seen});
    chk("drv_done", 32'h1, {31'h0, done_seen});
    chk("err", 32'h0, {19'h0, err});
    abort_at = 6;
    home(hrs_pkg::HRS_M_DRIVER, 1'b1, 1'b0, 1'b1, 1'b0, 32'sh32, 32'sh0);
    chk("drv_home_abort", 32'h1, {31'h0, abort_seen});
    chk("aborted_done", 32'h0, {31'h0, done_seen});
    complete_run();
  end
endmodule : hrs_sequencer_tb
